// [design/barc_blank.sv]
/*
 * Spike blanking filter: a fault must persist for the blanking count.
 * Assumes synchronous active-low reset and a 10 MHz clock.
 */
`timescale 1ns/1ps
`include "barc_map.svh"
module barc_blank #(
   parameter int BLANK_CYC = `BARC_BLANK_CYC
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   barc_fault_if.filt flt
);
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic trip;
   logic next_trip;
   logic raw;

   always_comb begin
      raw = flt.ovp_raw | flt.otp_raw;
      next_trip = 1'b0;
      next_cnt = 16'h0000;
      if (raw) begin
         // Counter saturates; trip only after full persistence.
         if (cnt >= 16'(BLANK_CYC - 1)) begin
            next_cnt = cnt;
            next_trip = 1'b1; // [R10] [R11]
         end else begin
            next_cnt = cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cnt <= 16'h0000;
         trip <= 1'b0;
      end else begin
         cnt <= next_cnt;
         trip <= next_trip;
      end
   end

   assign flt.trip = trip;
endmodule // barc_blank

// [design/barc_ctrl.sv]
/*
 * Mode controller for an off-line switcher: normal, burst and
 * auto-restart operation driven by comparator decisions.
 * Assumes all comparator inputs synchronous to CLK_IN, 10 MHz.
 */
`timescale 1ns/1ps
`include "barc_map.svh"

// Function
// R1 - Low-load comparator continuously watched; it opens the soft-start clamp switch.
// R2 - Soft-start clamped at 4.4V normally; blanking window starts on clamp release.
// R3 - Burst entered only when soft-start above 5.4V while low load persists.
// R4 - Burst entry sets burst flag and disables bias, stopping switching.
// R5 - With burst flag set, feedback above 4V re-enables bias and switching.
// R6 - During burst switching, feedback at 3.4V disables bias again.
// R7 - Burst mode selects the reduced 0.257V current limit.
// R8 - Overload above 4.8V in burst clears burst and restores full limit.
// R9 - Supply overvoltage counts only with soft-start below 4V and feedback above 4.8V.
// R10 - Qualified overvoltage must persist 8.0 us before auto-restart.
// R11 - Over-temperature passes the same 8.0 us blanking, then auto-restart.
// R12 - Auto-restart switches off reference and all blocks except supply lockout.
// R13 - Lockout turns startup cell on below 8.5V, off at 15V, then startup.
// R14 - Without remaining fault, switching resumes after soft-start duration automatically.
// R15 - Overload releases clamp; auto-restart when soft-start passes 5.4V still overloaded.
// R16 - Supply below 8.5V in operation turns off and restarts via startup cell.
// R17 - Gate output held low while supply is locked out.
// R18 - Startup cell kept off during burst mode.
// R19 - Qualifying condition lost before 5.4V cancels entry and re-closes the clamp.
// R20 - Lockout resets mode to startup with burst flag and auto-restart cleared.
module barc_ctrl
   import barc_pkg::*;
#(
   parameter int SOFTSTART_CYC = `BARC_SOFTSTART_CYC,
   parameter int BLANK_CYC = `BARC_BLANK_CYC
) (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic LOW_LOAD_CMP_IN,
   input wire logic SOFTSTART_WINDOW_CMP_IN,
   input wire logic OVERLOAD_CMP_IN,
   input wire logic BURST_ON_CMP_IN,
   input wire logic BURST_OFF_CMP_IN,
   input wire logic SUPPLY_OVERVOLTAGE_CMP_IN,
   input wire logic SOFTSTART_LOW_CMP_IN,
   input wire logic OVERTEMP_CMP_IN,
   input wire logic SUPPLY_TURN_OFF_LEVEL_IN,
   input wire logic SUPPLY_TURN_ON_LEVEL_IN,
   input wire logic PWM_GATE_IN,
   output logic SOFTSTART_CLAMP_SWITCH_OUT,
   output logic BIAS_EN_OUT,
   output logic REF_EN_OUT,
   output logic REDUCED_LIMIT_SEL_OUT,
   output logic STARTUP_CELL_OUT,
   output logic GATE_EN_OUT,
   output logic BURST_FLAG_OUT,
   output logic AUTO_RESTART_OUT,
   output logic SUPPLY_LOCKOUT_OUT
);
   // ***********************************************************
   // Declarations
   // ***********************************************************
   barc_fault_if flt ();
   barc_mode_t mode;
   barc_mode_t next_mode;
   logic [15:0] ss_cnt;
   logic [15:0] next_ss_cnt;
   logic clamp;
   logic next_clamp;
   logic bias;
   logic next_bias;
   logic ref_en;
   logic next_ref_en;
   logic rlim;
   logic next_rlim;
   logic gate_en;
   logic next_gate_en;
   logic lockout;
   logic in_burst;
   logic auto_restart_gate;
   logic burst_entry_gate;

   // ***********************************************************
   // Fault qualification and lockout
   // ***********************************************************
   // Overvoltage counts only in soft start with feedback out of range.
   assign flt.ovp_raw = SUPPLY_OVERVOLTAGE_CMP_IN & SOFTSTART_LOW_CMP_IN
      & OVERLOAD_CMP_IN & (mode != BARC_AUTO_RESTART); // [R9]
   assign flt.otp_raw = OVERTEMP_CMP_IN & (mode != BARC_AUTO_RESTART); // [R11]

   barc_blank #(.BLANK_CYC(BLANK_CYC)) u_blank (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .flt(flt)
   );

   assign in_burst = (mode == BARC_BURST_OFF) || (mode == BARC_BURST_ON);

   barc_lockout u_lockout (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .below_off_in(SUPPLY_TURN_OFF_LEVEL_IN),
      .above_on_in(SUPPLY_TURN_ON_LEVEL_IN),
      .inhibit_in(in_burst),
      .lockout_out(lockout),
      .startup_cell_out(STARTUP_CELL_OUT)
   );

   // Window comparator gates both mode entries after the blanking window.
   assign auto_restart_gate = SOFTSTART_WINDOW_CMP_IN & OVERLOAD_CMP_IN; // [R15]
   assign burst_entry_gate = SOFTSTART_WINDOW_CMP_IN & LOW_LOAD_CMP_IN; // [R3]

   // ***********************************************************
   // Mode state machine
   // ***********************************************************
   always_comb begin
      next_mode = mode;
      next_ss_cnt = ss_cnt;
      next_clamp = clamp;
      next_bias = bias;
      next_ref_en = ref_en;
      next_rlim = rlim;
      next_gate_en = gate_en;
      if (lockout) begin
         // Lockout forces startup and drops everything but the lockout.
         next_mode = BARC_STARTUP; // [R20] [R16]
         next_ss_cnt = 16'h0000;
         next_clamp = 1'b0;
         next_bias = 1'b0;
         next_ref_en = 1'b0;
         next_rlim = 1'b0;
         next_gate_en = 1'b0; // [R17]
      end else begin
         unique case (mode)
            BARC_STARTUP: begin
               next_bias = 1'b1;
               next_ref_en = 1'b1;
               next_rlim = 1'b0;
               next_clamp = 1'b0;
               next_gate_en = 1'b1;
               if (flt.trip) begin
                  next_mode = BARC_AUTO_RESTART;
               end else if (ss_cnt >= 16'(SOFTSTART_CYC - 1)) begin
                  // Soft start elapsed; node now clamped.
                  next_mode = BARC_NORMAL; // [R14]
                  next_clamp = 1'b1; // [R2]
               end else begin
                  next_ss_cnt = ss_cnt + 16'h0001;
               end
            end
            BARC_NORMAL: begin
               // Clamp opens on low load or overload, re-closes when gone.
               next_clamp = ~(LOW_LOAD_CMP_IN | OVERLOAD_CMP_IN); // [R1] [R15] [R19]
               if (flt.trip || auto_restart_gate) begin
                  next_mode = BARC_AUTO_RESTART; // [R10] [R11] [R15]
               end else if (burst_entry_gate) begin
                  next_mode = BARC_BURST_OFF; // [R3]
                  next_bias = 1'b0; // [R4]
                  next_gate_en = 1'b0; // [R4]
                  next_rlim = 1'b1; // [R7]
               end
            end
            BARC_BURST_OFF, BARC_BURST_ON: begin
               next_clamp = 1'b0;
               if (flt.trip) begin
                  next_mode = BARC_AUTO_RESTART;
               end else if (OVERLOAD_CMP_IN) begin
                  // Leave burst with full current available.
                  next_mode = BARC_NORMAL; // [R8]
                  next_rlim = 1'b0; // [R8]
                  next_bias = 1'b1;
                  next_gate_en = 1'b1;
                  next_clamp = 1'b1;
               end else if (mode == BARC_BURST_OFF && BURST_ON_CMP_IN) begin
                  next_mode = BARC_BURST_ON; // [R5]
                  next_bias = 1'b1; // [R5]
                  next_gate_en = 1'b1; // [R5]
               end else if (mode == BARC_BURST_ON && BURST_OFF_CMP_IN) begin
                  next_mode = BARC_BURST_OFF; // [R6]
                  next_bias = 1'b0; // [R6]
                  next_gate_en = 1'b0; // [R6]
               end
            end
            BARC_AUTO_RESTART: begin
               // Only the lockout runs; wait for supply to collapse.
               next_bias = 1'b0; // [R12]
               next_ref_en = 1'b0; // [R12]
               next_gate_en = 1'b0; // [R12]
               next_rlim = 1'b0;
               next_clamp = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         mode <= BARC_STARTUP; // [R20]
         ss_cnt <= 16'h0000;
         clamp <= 1'b0;
         bias <= 1'b0;
         ref_en <= 1'b0;
         rlim <= 1'b0;
         gate_en <= 1'b0;
      end else begin
         mode <= next_mode;
         ss_cnt <= next_ss_cnt;
         clamp <= next_clamp;
         bias <= next_bias;
         ref_en <= next_ref_en;
         rlim <= next_rlim;
         gate_en <= next_gate_en;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign SOFTSTART_CLAMP_SWITCH_OUT = clamp;
   assign BIAS_EN_OUT = bias;
   assign REF_EN_OUT = ref_en;
   assign REDUCED_LIMIT_SEL_OUT = rlim; // [R7]
   assign GATE_EN_OUT = gate_en & PWM_GATE_IN & ~lockout; // [R17]
   assign BURST_FLAG_OUT = in_burst; // [R4]
   assign AUTO_RESTART_OUT = (mode == BARC_AUTO_RESTART);
   assign SUPPLY_LOCKOUT_OUT = lockout;
endmodule // barc_ctrl

// [design/barc_lockout.sv]
/*
 * Supply lockout hysteresis and startup cell control.
 * Assumes comparator levels synchronous to the clock.
 */
`timescale 1ns/1ps
module barc_lockout (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic below_off_in,
   input wire logic above_on_in,
   input wire logic inhibit_in,
   output logic lockout_out,
   output logic startup_cell_out
);
   logic lock;
   logic next_lock;

   always_comb begin
      next_lock = lock;
      if (below_off_in) begin
         next_lock = 1'b1; // [R13] [R16]
      end else if (above_on_in) begin
         next_lock = 1'b0; // [R13]
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         lock <= 1'b1;
      end else begin
         lock <= next_lock;
      end
   end

   assign lockout_out = lock;
   // Startup cell charges the supply while locked out, never in burst.
   assign startup_cell_out = lock & ~inhibit_in; // [R18]
endmodule // barc_lockout

// [inc/barc_fault_if.sv]
/*
 * Interface carrying raw fault indications to the blanking filter and
 * the filtered trip back to the mode controller.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
interface barc_fault_if;
   logic ovp_raw;
   logic otp_raw;
   logic trip;
   modport ctrl (output ovp_raw, output otp_raw, input trip);
   modport filt (input ovp_raw, input otp_raw, output trip);
endinterface

// [inc/barc_map.svh]
/*
 * Constants for the burst and auto-restart controller: timing figures
 * and derived cycle counts.
 * Assumes a 10 MHz control clock.
 */
`ifndef BARC_MAP_SVH
`define BARC_MAP_SVH

// Control clock period in picoseconds.
`define BARC_CLK_PERIOD_PS 100_000
// Fault spike blanking time in nanoseconds.
`define BARC_BLANK_NS 8_000
// Blanking count, rounded up to whole cycles.
`define BARC_BLANK_CYC ((`BARC_BLANK_NS * 1000 + `BARC_CLK_PERIOD_PS - 1) / `BARC_CLK_PERIOD_PS)
// Soft start duration in cycles (application dependent, chosen default).
`define BARC_SOFTSTART_CYC 200

`endif

// [inc/barc_pkg.sv]
/*
 * Types shared by the burst and auto-restart controller modules.
 * Assumes nothing of its surroundings.
 */
package barc_pkg;

   typedef enum logic [2:0] {
      BARC_STARTUP,
      BARC_NORMAL,
      BARC_BURST_OFF,
      BARC_BURST_ON,
      BARC_AUTO_RESTART
   } barc_mode_t;

endpackage

// [verif/barc_ctrl_checker.sv]
/* Port assertions for the burst and auto-restart mode controller.
   Assumes it is bound into barc_ctrl and shares its clock and reset. */
`timescale 1ns/1ps
module barc_ctrl_checker #(
   parameter int BLANK_CYC = 80
) (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic LOW_LOAD_CMP_IN,
   input wire logic SOFTSTART_WINDOW_CMP_IN,
   input wire logic OVERLOAD_CMP_IN,
   input wire logic BURST_ON_CMP_IN,
   input wire logic BURST_OFF_CMP_IN,
   input wire logic SUPPLY_OVERVOLTAGE_CMP_IN,
   input wire logic SOFTSTART_LOW_CMP_IN,
   input wire logic OVERTEMP_CMP_IN,
   input wire logic SOFTSTART_CLAMP_SWITCH_OUT,
   input wire logic BIAS_EN_OUT,
   input wire logic REF_EN_OUT,
   input wire logic REDUCED_LIMIT_SEL_OUT,
   input wire logic GATE_EN_OUT,
   input wire logic BURST_FLAG_OUT,
   input wire logic AUTO_RESTART_OUT,
   input wire logic SUPPLY_LOCKOUT_OUT
);
   // ****************
   // Properties
   // ****************
   int fault_cnt;
   int next_fault_cnt;
   always_comb begin
      next_fault_cnt = 0;
      // Counts during lockout too, so it never lags the blanking counter.
      if (OVERTEMP_CMP_IN || (SUPPLY_OVERVOLTAGE_CMP_IN && SOFTSTART_LOW_CMP_IN &&
          OVERLOAD_CMP_IN)) begin
         next_fault_cnt = fault_cnt + 1;
      end
   end
   always_ff @(posedge CLK_IN) begin
      fault_cnt <= RESETN_IN ? next_fault_cnt : 0;
   end
   // Settled marks normal operation: the clamp has closed since the last lockout.
   logic settled;
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN || SUPPLY_LOCKOUT_OUT) begin
         settled <= 1'b0;
      end else if (SOFTSTART_CLAMP_SWITCH_OUT) begin
         settled <= 1'b1;
      end
   end
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   property p_open;
      SOFTSTART_CLAMP_SWITCH_OUT && LOW_LOAD_CMP_IN && !SUPPLY_LOCKOUT_OUT
         |=> !SOFTSTART_CLAMP_SWITCH_OUT;
   endproperty
   a_open: assert property (p_open)
      else $error("Clamp stayed closed at low load.");
   property p_enter;
      settled && REF_EN_OUT && !SUPPLY_LOCKOUT_OUT && !BURST_FLAG_OUT && !AUTO_RESTART_OUT &&
         fault_cnt < BLANK_CYC && !OVERLOAD_CMP_IN && LOW_LOAD_CMP_IN && SOFTSTART_WINDOW_CMP_IN
         |=> BURST_FLAG_OUT && !BIAS_EN_OUT && REDUCED_LIMIT_SEL_OUT;
   endproperty
   a_enter: assert property (p_enter)
      else $error("Burst entry missed.");
   property p_bon;
      BURST_FLAG_OUT && !BIAS_EN_OUT && BURST_ON_CMP_IN && !OVERLOAD_CMP_IN &&
         !SUPPLY_LOCKOUT_OUT && fault_cnt < BLANK_CYC |=> BIAS_EN_OUT;
   endproperty
   a_bon: assert property (p_bon)
      else $error("Bias not restored in burst.");
   property p_boff;
      BURST_FLAG_OUT && BIAS_EN_OUT && BURST_OFF_CMP_IN && !OVERLOAD_CMP_IN |=> !BIAS_EN_OUT;
   endproperty
   a_boff: assert property (p_boff)
      else $error("Bias not removed in burst.");
   property p_leave;
      BURST_FLAG_OUT && OVERLOAD_CMP_IN |=> !BURST_FLAG_OUT && !REDUCED_LIMIT_SEL_OUT;
   endproperty
   a_leave: assert property (p_leave)
      else $error("Burst not left on overload.");
   property p_cause;
      $rose(AUTO_RESTART_OUT) |-> $past(fault_cnt) >= BLANK_CYC ||
         $past(OVERLOAD_CMP_IN) && $past(SOFTSTART_WINDOW_CMP_IN);
   endproperty
   a_cause: assert property (p_cause)
      else $error("Auto-restart without a persistent fault.");
   property p_quiet;
      AUTO_RESTART_OUT && $past(AUTO_RESTART_OUT) |-> !REF_EN_OUT && !BIAS_EN_OUT && !GATE_EN_OUT;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("Blocks active in auto-restart.");
   property p_lock;
      SUPPLY_LOCKOUT_OUT && $past(SUPPLY_LOCKOUT_OUT)
         |-> !GATE_EN_OUT && !BURST_FLAG_OUT && !AUTO_RESTART_OUT;
   endproperty
   a_lock: assert property (p_lock)
      else $error("Mode not held during lockout.");
   c_burst: cover property ($rose(BURST_FLAG_OUT));
   c_restart: cover property ($rose(AUTO_RESTART_OUT));
   c_lock: cover property ($rose(SUPPLY_LOCKOUT_OUT));
endmodule // barc_ctrl_checker
bind barc_ctrl barc_ctrl_checker #(.BLANK_CYC(BLANK_CYC)) barc_ctrl_checker_inst (.*);

// [verif/barc_power_model.sv]
/* Behavioural feedback, supply and junction comparators and soft-start node.
   Assumes the bench sets feedback, supply and junction levels. */
`timescale 1ns/1ps
module barc_power_model (
   input wire logic clk_in,
   input wire logic clamp_in,
   input wire logic lockout_in,
   input var int fb_mv_in,
   input var int vcc_mv_in,
   input var int tj_c_in,
   output logic [9:0] cmp_out
);
   // ****************
   // Soft-start node
   // ****************
   int ss_mv = 0;
   always @(negedge clk_in) begin
      if (lockout_in) begin
         ss_mv = 0;
      end else if (clamp_in && ss_mv >= 4400) begin
         ss_mv = 4400;
      end else if (ss_mv < 6500) begin
         ss_mv = ss_mv + 10;
      end
   end
   assign cmp_out = {fb_mv_in < 1320, ss_mv > 5400, fb_mv_in > 4800, fb_mv_in > 4000,
      fb_mv_in <= 3400, vcc_mv_in > 17000, ss_mv < 4000, tj_c_in > 140,
      vcc_mv_in < 8500, vcc_mv_in >= 15000};
endmodule // barc_power_model

// [verif/burst_and_auto_restart_control_test.sv]
/* Self-checking bench for the burst and auto-restart mode controller.
   Assumes the power stage model drives every comparator input. */
`timescale 1ns/1ps
module burst_and_auto_restart_control_test;
   localparam int SS_CYC = 100;
   localparam int BLANK = 80;
   logic CLK_IN = 1'b0;
   logic RESETN_IN = 1'b0;
   logic PWM_GATE_IN = 1'b0;
   logic [9:0] cmp;
   int fb = 2500, vcc = 12000, tj = 25, waited = 0, mismatches = 0, check_count = 0;
   wire LOW_LOAD_CMP_IN, SOFTSTART_WINDOW_CMP_IN, OVERLOAD_CMP_IN, BURST_ON_CMP_IN;
   wire BURST_OFF_CMP_IN, SUPPLY_OVERVOLTAGE_CMP_IN, SOFTSTART_LOW_CMP_IN, OVERTEMP_CMP_IN;
   wire SUPPLY_TURN_OFF_LEVEL_IN, SUPPLY_TURN_ON_LEVEL_IN, SOFTSTART_CLAMP_SWITCH_OUT;
   wire BIAS_EN_OUT, REF_EN_OUT, REDUCED_LIMIT_SEL_OUT, STARTUP_CELL_OUT, GATE_EN_OUT;
   wire BURST_FLAG_OUT, AUTO_RESTART_OUT, SUPPLY_LOCKOUT_OUT;
   wire [6:0] outs = {GATE_EN_OUT, BIAS_EN_OUT, REF_EN_OUT, SOFTSTART_CLAMP_SWITCH_OUT,
      BURST_FLAG_OUT, AUTO_RESTART_OUT, SUPPLY_LOCKOUT_OUT};
   assign {LOW_LOAD_CMP_IN, SOFTSTART_WINDOW_CMP_IN, OVERLOAD_CMP_IN, BURST_ON_CMP_IN,
      BURST_OFF_CMP_IN, SUPPLY_OVERVOLTAGE_CMP_IN, SOFTSTART_LOW_CMP_IN, OVERTEMP_CMP_IN,
      SUPPLY_TURN_OFF_LEVEL_IN, SUPPLY_TURN_ON_LEVEL_IN} = cmp;
   barc_ctrl #(.SOFTSTART_CYC(SS_CYC), .BLANK_CYC(BLANK)) barc_ctrl_inst (.*);
   barc_power_model barc_power_model_inst (.clk_in(CLK_IN), .clamp_in(SOFTSTART_CLAMP_SWITCH_OUT),
      .lockout_in(SUPPLY_LOCKOUT_OUT), .fb_mv_in(fb), .vcc_mv_in(vcc), .tj_c_in(tj),
      .cmp_out(cmp));
   initial begin
      forever #50 CLK_IN = ~CLK_IN;
   end
   // ****************
   // Helpers and expected-state model
   // ****************
   task automatic check(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("mismatches %0d check_count %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge CLK_IN);
   endtask
   task automatic wait_bit(input int idx, input logic val, input int lim);
      waited = 0;
      while (outs[idx] !== val) begin
         cyc(1);
         waited++;
         if (waited > lim) begin
            check("wait", val, outs[idx]);
            give_verdict();
         end
      end
   endtask
   // Mode 0 is locked out, 1 running, 2 burst, 3 auto-restart.
   task automatic check_mode(input int m);
      check("lockout", m == 0, SUPPLY_LOCKOUT_OUT);
      check("startup_cell", m == 0, STARTUP_CELL_OUT);
      check("burst_flag", m == 2, BURST_FLAG_OUT);
      check("reduced_limit", m == 2, REDUCED_LIMIT_SEL_OUT);
      check("auto_restart", m == 3, AUTO_RESTART_OUT);
      if (m % 2) check("ref_en", m == 1, REF_EN_OUT);
   endtask
   task automatic restart();
      PWM_GATE_IN = 1'b1;
      vcc = 8000;
      wait_bit(0, 1'b1, 4);
      cyc(1);
      check_mode(0);
      check("gate_en", 1'b0, GATE_EN_OUT);
      vcc = 16000;
      wait_bit(0, 1'b0, 4);
   endtask
   task automatic to_normal();
      wait_bit(3, 1'b1, SS_CYC + 10);
      cyc(400);
      check_mode(1);
   endtask
   initial begin
      void'($urandom(32'h90f3_7ecc));
      cyc(8);
      RESETN_IN = 1'b1;
      cyc(1);
      check_mode(0);
      vcc = 16000;
      wait_bit(0, 1'b0, 4);
      fb = 5000;
      vcc = 18000;
      cyc(BLANK - 10);
      fb = 2500;
      vcc = 16000;
      cyc(3);
      check("auto_restart", 1'b0, AUTO_RESTART_OUT);
      to_normal();
      repeat (8) begin
         PWM_GATE_IN = 1'($urandom);
         #1;
         check("gate_en", PWM_GATE_IN, GATE_EN_OUT);
         cyc(1);
      end
      fb = 1000;
      cyc(1);
      check("clamp", 1'b0, SOFTSTART_CLAMP_SWITCH_OUT);
      cyc(50);
      fb = 2500;
      cyc(2);
      check("clamp", 1'b1, SOFTSTART_CLAMP_SWITCH_OUT);
      check_mode(1);
      fb = 1000;
      wait_bit(2, 1'b1, 200);
      check("entry_delay", 1'b1, waited >= 98 && waited <= 106);
      check_mode(2);
      check("bias_en", 1'b0, BIAS_EN_OUT);
      fb = 4100;
      cyc(1);
      check("bias_en", 1'b1, BIAS_EN_OUT);
      fb = 3400;
      cyc(1);
      check("bias_en", 1'b0, BIAS_EN_OUT);
      fb = 5000;
      cyc(1);
      check("burst_flag", 1'b0, BURST_FLAG_OUT);
      check("reduced_limit", 1'b0, REDUCED_LIMIT_SEL_OUT);
      fb = 1000;
      wait_bit(2, 1'b1, 200);
      vcc = 8000;
      cyc(1);
      check("lockout", 1'b1, SUPPLY_LOCKOUT_OUT);
      check("startup_cell", 1'b0, STARTUP_CELL_OUT);
      fb = 2500;
      restart();
      fb = 5000;
      vcc = 18000;
      wait_bit(1, 1'b1, BLANK + 10);
      check("trip_delay", 1'b1, waited >= BLANK && waited <= BLANK + 3);
      cyc(2);
      check_mode(3);
      check("bias_en", 1'b0, BIAS_EN_OUT);
      vcc = 16000;
      fb = 2500;
      cyc(20);
      check_mode(3);
      restart();
      to_normal();
      vcc = 18000;
      cyc(BLANK + 20);
      check_mode(1);
      vcc = 16000;
      fb = 5000;
      cyc(1);
      check("clamp", 1'b0, SOFTSTART_CLAMP_SWITCH_OUT);
      wait_bit(1, 1'b1, 200);
      check("overload_delay", 1'b1, waited >= 96 && waited <= 106);
      fb = 2500;
      restart();
      to_normal();
      tj = 150;
      wait_bit(1, 1'b1, BLANK + 10);
      check("hot_delay", 1'b1, waited >= BLANK && waited <= BLANK + 3);
      give_verdict();
   end
endmodule // burst_and_auto_restart_control_test
